// *** logic/vrc_pkg.sv ***
/*
 * package of the voice recorder command/status block: command codes, status
 * bit positions, reset values and processing times in oscillator clocks.
 * assumes a single 10 MHz sys_clk standing in for the oscillator clock.
 */
`default_nettype none

package vrc_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int RESET_PROC_CLKS = 24600;
    localparam int CMD_SHORT_CLKS = 35;
    localparam int CMD_LONG_CLKS = 70;
    localparam int EOS_START_MIN_CLKS = 32;
    localparam int EOS_PLAY_MIN_CLKS = 48;
    localparam int TIMER_W = 15;

    // ==========================================================
    // command opcodes
    localparam logic [3:0] OP_NOP = 4'h1;
    localparam logic [3:0] OP_START = 4'h2;
    localparam logic [3:0] OP_STOP = 4'h3;
    localparam logic [3:0] OP_CNT_LOAD = 4'h4;
    localparam logic [3:0] OP_STOP_LOAD = 4'h5;
    localparam logic [3:0] OP_COND = 4'h6;
    localparam logic [3:0] OP_PHRASE = 4'h7;
    localparam logic [3:0] OP_CNT_READ = 4'h8;
    localparam logic [3:0] OP_REC_ARM = 4'h9;
    localparam logic [3:0] OP_MEM_READ = 4'hA;
    localparam logic [3:0] OP_MEM_WRITE = 4'hB;

    // ==========================================================
    // status nibble layout
    localparam int ST_EOS_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_OVR_BIT = 2;

    // ==========================================================
    // address space and reset values
    localparam int ADDR_W = 20;
    localparam logic [19:0] ADDR_DATA_BASE = 20'h0_0100;
    localparam logic [19:0] ADDR_MAX_DEFAULT = 20'h1_FFFF;
    localparam logic [19:0] ADDR_ZERO = 20'h0_0000;
    localparam logic [2:0] NIB_CNT_LOAD = 3'h5;
    localparam logic [2:0] NIB_COND = 3'h1;
    localparam logic [2:0] NIB_PHRASE = 3'h2;
    localparam logic [2:0] NIB_MEM_WRITE = 3'h2;
    localparam logic [2:0] NIB_CNT_READ = 3'h5;
    localparam logic [2:0] NIB_MEM_READ = 3'h2;

    typedef enum logic [3:0]
    {
        ST_REC_WAIT = 4'b0001,
        ST_RECORD = 4'b0010,
        ST_PLAY_WAIT = 4'b0100,
        ST_PLAY = 4'b1000
    } vrc_mode_type;

    typedef struct packed
    {
        logic spare;
        logic overflow_flag;
        logic busy;
        logic end_of_sequence;
    } vrc_status_type;

endpackage : vrc_pkg

`default_nettype wire

// *** logic/vrc_strobe_sync.sv ***
/*
 * two-flop synchroniser and edge finder for one active-low host strobe.
 * assumes the strobe is asynchronous to sys_clk; idle level is high.
 */
`timescale 1ns/100ps
`default_nettype none

module vrc_strobe_sync
    import vrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic strobe_n,
    output logic level_n,
    output logic rise
);

    // ==========================================================
    // synchroniser: first stage is read only by the second
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end
        else
        begin
            meta_r <= strobe_n;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_n = sync_r;
    assign rise = sync_r & ~prev_r;

endmodule : vrc_strobe_sync

`default_nettype wire

// *** logic/vrc_timer.sv ***
/*
 * down-counter timing command processing and reset initialisation.
 * assumes load and load_val come from logic on sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module vrc_timer
    import vrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [TIMER_W-1:0] load_val,
    output logic running,
    output logic done
);

    // ==========================================================
    // counter; done pulses in the last cycle before the count reaches zero
    logic [TIMER_W-1:0] count_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            count_r <= '0;
        else if (load)
            count_r <= load_val;
        else if (count_r != '0)
            count_r <= count_r - 1'b1;
    end

    assign running = (count_r != '0);
    assign done = (count_r == TIMER_W'(1)) & ~load;

endmodule : vrc_timer

`default_nettype wire

// *** logic/vrc_cmd_status.sv ***
/*
 * host command interpreter and status nibble of a voice record/playback
 * controller under processor control. assumes host strobes and the clear pin
 * are asynchronous; the memory datapath is outside this block.
 */
`timescale 1ns/100ps
`default_nettype none

module vrc_cmd_status
    import vrc_pkg::*;
#(
    parameter int RESET_CLKS = RESET_PROC_CLKS,
    parameter logic [19:0] MAX_ADDR = ADDR_MAX_DEFAULT
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clear_all_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] host_nibble_in,
    output logic [3:0] host_nibble_out,
    output logic host_nibble_oe,
    output logic end_of_sequence,
    output logic [19:0] address_counter,
    output logic [1:0] bit_rate,
    output logic [5:0] phrase_number,
    output logic phrase_mode
);

    // ==========================================================
    // pin synchronisers
    logic rd_lvl_n;
    logic wr_lvl_n;
    logic wr_rise;
    logic clr_meta_r;
    logic clr_sync_r;
    logic [3:0] din_meta_r;
    logic [3:0] din_r;

    vrc_strobe_sync u_rd_sync
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .strobe_n(rd_n),
        .level_n(rd_lvl_n),
        .rise()
    );

    vrc_strobe_sync u_wr_sync
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .strobe_n(wr_n),
        .level_n(wr_lvl_n),
        .rise(wr_rise)
    );

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            clr_meta_r <= 1'b0;
            clr_sync_r <= 1'b0;
            din_meta_r <= 4'h0;
            din_r <= 4'h0;
        end
        else
        begin
            clr_meta_r <= clear_all_n;
            clr_sync_r <= clr_meta_r;
            din_meta_r <= host_nibble_in;
            din_r <= din_meta_r;
        end
    end

    // clear held low acts as a block-wide reset
    logic clr_active;
    assign clr_active = ~clr_sync_r;

    // ==========================================================
    // processing timer
    function automatic logic [TIMER_W-1:0] proc_time(input logic is_long);
        proc_time = is_long ? TIMER_W'(CMD_LONG_CLKS) : TIMER_W'(CMD_SHORT_CLKS);
    endfunction : proc_time

    logic tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic tmr_run;
    logic tmr_done;
    logic clr_prev_r;

    vrc_timer u_timer
    (
        .sys_clk(sys_clk),
        .reset(reset | clr_active),
        .load(tmr_load),
        .load_val(tmr_val),
        .running(tmr_run),
        .done(tmr_done)
    );

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            clr_prev_r <= 1'b0;
        else
            clr_prev_r <= clr_sync_r;
    end

    logic clr_release;
    assign clr_release = clr_sync_r & ~clr_prev_r;

    // ==========================================================
    // command sequencing
    logic [3:0] op_r;
    logic [2:0] nib_left_r;
    logic [2:0] rd_left_r;
    logic rd_prev_r;
    logic rd_rise;
    logic accept;
    logic is_long;

    assign rd_rise = rd_lvl_n & ~rd_prev_r;
    assign accept = wr_rise & ~tmr_run;
    assign is_long = (nib_left_r != 3'h0) ? (op_r == OP_PHRASE)
        : (din_r == OP_PHRASE) | (din_r == OP_MEM_READ) | (din_r == OP_CNT_READ);

    always_comb
    begin
        tmr_load = 1'b0;
        tmr_val = proc_time(1'b0);
        if (clr_release)
        begin
            tmr_load = 1'b1;
            tmr_val = TIMER_W'(RESET_CLKS);
        end
        else if (accept)
        begin
            tmr_load = 1'b1;
            tmr_val = proc_time(is_long);
        end
        else if (rd_rise && rd_left_r != 3'h0)
        begin
            tmr_load = 1'b1;
            tmr_val = proc_time(1'b1);
        end
    end

    // decoded at the edge the nibble is taken; data nibbles override opcode view
    logic op_now;
    assign op_now = accept & (nib_left_r == 3'h0);

    always_ff @(posedge sys_clk)
    begin
        if (reset || clr_active)
        begin
            op_r <= OP_NOP;
            nib_left_r <= 3'h0;
            rd_left_r <= 3'h0;
            rd_prev_r <= 1'b1;
        end
        else
        begin
            rd_prev_r <= rd_lvl_n;
            if (op_now)
            begin
                op_r <= din_r;
                case (din_r)
                    OP_CNT_LOAD, OP_STOP_LOAD: nib_left_r <= NIB_CNT_LOAD;
                    OP_COND: nib_left_r <= NIB_COND;
                    OP_PHRASE: nib_left_r <= NIB_PHRASE;
                    OP_MEM_WRITE: nib_left_r <= NIB_MEM_WRITE;
                    default: nib_left_r <= 3'h0;
                endcase
                case (din_r)
                    OP_CNT_READ: rd_left_r <= NIB_CNT_READ;
                    OP_MEM_READ: rd_left_r <= NIB_MEM_READ;
                    default: rd_left_r <= 3'h0;
                endcase
            end
            else if (accept)
                nib_left_r <= nib_left_r - 3'h1;
            else if (rd_rise && rd_left_r != 3'h0)
                rd_left_r <= rd_left_r - 3'h1;
        end
    end

    // ==========================================================
    // address registers and condition settings
    logic [19:0] addr_r;
    logic [19:0] stop_addr_r;
    logic cmp_en_r;
    logic ovf_det_en_r;
    logic [1:0] rate_r;
    logic [5:0] phrase_r;
    logic phrase_mode_r;
    logic count_run_r;
    logic data_nib;
    logic [2:0] nib_idx;

    assign data_nib = accept & (nib_left_r != 3'h0);
    assign nib_idx = NIB_CNT_LOAD - nib_left_r;

    vrc_mode_type mode_r;
    logic [1:0] stop_cnt_r;
    logic ovf_hit;
    logic cmp_hit;

    assign ovf_hit = (mode_r == ST_RECORD) & ovf_det_en_r & phrase_mode_r
        & (addr_r == MAX_ADDR);
    assign cmp_hit = count_run_r & cmp_en_r & (addr_r == stop_addr_r);

    always_ff @(posedge sys_clk)
    begin
        if (reset || clr_active)
        begin
            addr_r <= ADDR_DATA_BASE;
            stop_addr_r <= ADDR_ZERO;
            cmp_en_r <= 1'b0;
            ovf_det_en_r <= 1'b1;
            rate_r <= 2'h0;
            phrase_r <= 6'h00;
            phrase_mode_r <= 1'b0;
            count_run_r <= 1'b0;
        end
        else
        begin
            if (ovf_hit)
            begin
                addr_r <= ADDR_DATA_BASE;
                count_run_r <= 1'b0;
            end
            else if (cmp_hit)
                count_run_r <= 1'b0;
            else if (count_run_r)
                addr_r <= addr_r + 20'h0_0001;
            if (data_nib && op_r == OP_CNT_LOAD)
                addr_r[nib_idx*4 +: 4] <= din_r;
            if (data_nib && op_r == OP_STOP_LOAD)
                stop_addr_r[nib_idx*4 +: 4] <= din_r;
            if (data_nib && op_r == OP_COND)
            begin
                ovf_det_en_r <= din_r[2];
                rate_r <= din_r[1:0];
            end
            if (data_nib && op_r == OP_PHRASE)
            begin
                if (nib_left_r == NIB_PHRASE)
                    phrase_r[3:0] <= din_r;
                else
                begin
                    phrase_r[5:4] <= din_r[1:0];
                    phrase_mode_r <= 1'b1;
                    count_run_r <= 1'b1;
                end
            end
            if (op_now)
            begin
                case (din_r)
                    OP_START:
                    begin
                        count_run_r <= 1'b1;
                        phrase_mode_r <= 1'b0;
                    end
                    OP_STOP: count_run_r <= 1'b0;
                    OP_CNT_LOAD: cmp_en_r <= 1'b0;
                    OP_STOP_LOAD: cmp_en_r <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // record/playback mode machine
    logic run_now;
    assign run_now = (op_now & (din_r == OP_START))
        | (data_nib & (op_r == OP_PHRASE) & (nib_left_r == 3'h1));

    always_ff @(posedge sys_clk)
    begin
        if (reset || clr_active)
        begin
            mode_r <= ST_REC_WAIT;
            stop_cnt_r <= 2'h0;
        end
        else
        begin
            case (mode_r)
                ST_REC_WAIT:
                begin
                    if (run_now)
                        mode_r <= ST_RECORD;
                    // a phrase opcode waits here until its data nibbles start recording
                    else if (op_now && din_r != OP_STOP && din_r != OP_NOP
                        && din_r != OP_REC_ARM && din_r != OP_START && din_r != OP_PHRASE)
                        mode_r <= ST_PLAY_WAIT;
                end
                ST_RECORD:
                begin
                    if ((op_now && din_r == OP_STOP) || ovf_hit || cmp_hit)
                        mode_r <= ST_REC_WAIT;
                end
                ST_PLAY_WAIT:
                begin
                    stop_cnt_r <= 2'h0;
                    if (run_now)
                        mode_r <= ST_PLAY;
                    else if (op_now && din_r == OP_REC_ARM)
                        mode_r <= ST_REC_WAIT;
                end
                ST_PLAY:
                begin
                    if (cmp_hit)
                        mode_r <= ST_PLAY_WAIT;
                    else if (op_now && din_r == OP_STOP)
                    begin
                        // first stop pauses, second one ends playback
                        if (stop_cnt_r == 2'h1)
                            mode_r <= ST_PLAY_WAIT;
                        stop_cnt_r <= stop_cnt_r + 2'h1;
                    end
                end
                default: mode_r <= ST_REC_WAIT;
            endcase
        end
    end

    // ==========================================================
    // end-of-sequence delay: fixed at the minimum of the window
    logic [6:0] eos_cnt_r;
    logic eos_r;
    logic eos_target;
    logic mode_is_wait;

    assign mode_is_wait = (mode_r == ST_REC_WAIT) | (mode_r == ST_PLAY_WAIT);
    assign eos_target = mode_is_wait;

    always_ff @(posedge sys_clk)
    begin
        if (reset || clr_active)
        begin
            eos_r <= 1'b1;
            eos_cnt_r <= 7'h00;
        end
        else if (eos_target == eos_r)
            eos_cnt_r <= 7'h00;
        else if (!eos_target && eos_cnt_r == 7'h00)
            eos_cnt_r <= (mode_r == ST_PLAY && phrase_mode_r)
                ? 7'(EOS_PLAY_MIN_CLKS) : 7'(EOS_START_MIN_CLKS);
        else if (eos_target)
            eos_r <= 1'b1;
        else if (eos_cnt_r == 7'h01)
            eos_r <= 1'b0;
        else
            eos_cnt_r <= eos_cnt_r - 7'h01;
    end

    // ==========================================================
    // status flags and host bus drive
    logic ovr_r;
    logic busy_r;
    vrc_status_type status;

    always_ff @(posedge sys_clk)
    begin
        if (reset || clr_active)
            ovr_r <= 1'b0;
        else if (ovf_hit)
            ovr_r <= 1'b1;
        else if (tmr_done && op_r == OP_NOP && nib_left_r == 3'h0)
            ovr_r <= 1'b0;
    end

    // busy covers the timer and any outstanding data nibbles
    always_ff @(posedge sys_clk)
    begin
        if (reset || clr_active)
            busy_r <= 1'b1;
        else if (tmr_load || tmr_run)
            busy_r <= 1'b1;
        else if (nib_left_r != 3'h0)
            busy_r <= 1'b1;
        else
            busy_r <= 1'b0;
    end

    always_comb
    begin
        status.spare = 1'b0;
        status.overflow_flag = ovr_r;
        status.busy = busy_r;
        status.end_of_sequence = eos_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            host_nibble_out <= 4'h0;
            host_nibble_oe <= 1'b0;
        end
        else
        begin
            host_nibble_out <= status;
            host_nibble_oe <= ~rd_lvl_n;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            end_of_sequence <= 1'b1;
            address_counter <= ADDR_DATA_BASE;
            bit_rate <= 2'h0;
            phrase_number <= 6'h00;
            phrase_mode <= 1'b0;
        end
        else
        begin
            end_of_sequence <= eos_r;
            address_counter <= addr_r;
            bit_rate <= rate_r;
            phrase_number <= phrase_r;
            phrase_mode <= phrase_mode_r;
        end
    end

    // ==========================================================
    // checks
    property p_busy_after_write;
        @(posedge sys_clk) disable iff (reset)
        accept |=> busy_r [*8];
    endproperty
    a_busy_after_write: assert property (p_busy_after_write)
        else $error("busy not held after write");

    property p_busy_in_clear;
        @(posedge sys_clk) disable iff (reset)
        clr_active |=> busy_r;
    endproperty
    a_busy_in_clear: assert property (p_busy_in_clear)
        else $error("busy low during clear");

    property p_short_time;
        @(posedge sys_clk) disable iff (reset || clr_active)
        (accept && !is_long) |=> ##[35:36] !tmr_run;
    endproperty
    a_short_time: assert property (p_short_time)
        else $error("short processing time wrong");

    property p_long_time;
        @(posedge sys_clk) disable iff (reset || clr_active)
        (accept && is_long) |=> tmr_run [*8] ##[63:64] !tmr_run;
    endproperty
    a_long_time: assert property (p_long_time)
        else $error("long processing time wrong");

    property p_spare_zero;
        @(posedge sys_clk) disable iff (reset)
        host_nibble_oe |-> host_nibble_out[3] == 1'b0;
    endproperty
    a_spare_zero: assert property (p_spare_zero)
        else $error("spare status bit set");

    property p_ovr_on_overflow;
        @(posedge sys_clk) disable iff (reset || clr_active)
        ovf_hit |=> ovr_r && addr_r == ADDR_DATA_BASE && mode_r == ST_REC_WAIT;
    endproperty
    a_ovr_on_overflow: assert property (p_ovr_on_overflow)
        else $error("overflow handling wrong");

    property p_eos_wait;
        @(posedge sys_clk) disable iff (reset || clr_active)
        mode_is_wait |=> ##1 eos_r;
    endproperty
    a_eos_wait: assert property (p_eos_wait)
        else $error("eos not set in waiting state");

    property p_eos_delay;
        @(posedge sys_clk) disable iff (reset || clr_active)
        $rose(mode_r == ST_RECORD) |-> eos_r [*8] ##[24:40] !eos_r;
    endproperty
    a_eos_delay: assert property (p_eos_delay)
        else $error("eos delay out of window");

    property p_bus_release;
        @(posedge sys_clk) disable iff (reset)
        rd_lvl_n |=> !host_nibble_oe;
    endproperty
    a_bus_release: assert property (p_bus_release)
        else $error("bus driven with read high");

endmodule : vrc_cmd_status

`default_nettype wire

// *** sim/vrc_host_model.sv ***
/* host processor model on the nibble bus: status reads and nibble writes.
   assumes its tasks are called from the falling edge of sys_clk. */
`timescale 1ns/100ps
`default_nettype none
module vrc_host_model
    import vrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [3:0] host_nibble_out,
    input wire logic host_nibble_oe,
    output var logic rd_n,
    output var logic wr_n,
    output var logic [3:0] host_nibble_in
);
    // ==========================================================
    // bus cycles
    initial
    begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        host_nibble_in = 4'h0;
    end
    task automatic rd_status(output logic [3:0] st);
        int n;
        n = 0;
        rd_n = 1'b0;
        while (host_nibble_oe !== 1'b1 && n < 9)
        begin
            @(negedge sys_clk);
            n++;
        end
        st = host_nibble_out;
        rd_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : rd_status
    // released data lines show the inverse, not a stale copy
    task automatic wr_nib(input logic [3:0] d);
        host_nibble_in = d;
        @(negedge sys_clk);
        wr_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        wr_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        host_nibble_in = ~d;
    endtask : wr_nib
    task automatic wait_idle();
        logic [3:0] st;
        st = 4'hF;
        while (st[ST_BUSY_BIT] !== 1'b0)
            rd_status(st);
    endtask : wait_idle
endmodule : vrc_host_model
`default_nettype wire

// *** sim/vrc_cmd_status_tb.sv ***
/* bench of the command/status block driven through the host model.
   assumes the init count is shortened to RC clocks. */
`timescale 1ns/100ps
`default_nettype none
module vrc_cmd_status_tb;
    import vrc_pkg::*;
    localparam int RC = 50;
    // small max address so phrase recording can run into it
    localparam logic [19:0] MAX_A = 20'h0_8000;
    logic sys_clk, reset, clear_all_n, rd_n, wr_n, host_nibble_oe, end_of_sequence, phrase_mode;
    logic [3:0] host_nibble_in, host_nibble_out, st;
    logic [19:0] address_counter, av;
    logic [1:0] bit_rate;
    logic [5:0] phrase_number, ph;
    logic [31:0] seed = 32'h60fe_a57f;
    int fail_count = 0, compares = 0, cyc = 0, t_wr = 0, t_eos = 0, t;
    // ==========================================================
    // design, host and clock
    vrc_cmd_status #(.RESET_CLKS(RC), .MAX_ADDR(MAX_A)) u_vrc_cmd_status (.sys_clk(sys_clk),
        .reset(reset),
        .clear_all_n(clear_all_n), .rd_n(rd_n), .wr_n(wr_n), .host_nibble_in(host_nibble_in),
        .host_nibble_out(host_nibble_out), .host_nibble_oe(host_nibble_oe),
        .end_of_sequence(end_of_sequence), .address_counter(address_counter),
        .bit_rate(bit_rate), .phrase_number(phrase_number), .phrase_mode(phrase_mode));
    vrc_host_model u_vrc_host_model (.sys_clk(sys_clk), .host_nibble_out(host_nibble_out),
        .host_nibble_oe(host_nibble_oe), .rd_n(rd_n), .wr_n(wr_n), .host_nibble_in(host_nibble_in));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    always @(posedge wr_n) t_wr = cyc;
    always @(end_of_sequence) t_eos = cyc;
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input bit ok, input string m);
        compares++;
        if (!ok)
        begin
            $display("[FAIL] %0t %s", $time, m);
            fail_count++;
        end
    endtask : chk
    task automatic busy_len(output int n);
        int t0;
        t0 = cyc;
        st = 4'hF;
        while (st[ST_BUSY_BIT] !== 1'b0 && cyc - t0 < 400)
            u_vrc_host_model.rd_status(st);
        n = cyc - t0;
    endtask : busy_len
    // the measured busy time carries a few clocks of strobe sync lag
    task automatic send(input logic [3:0] d, input int c, input bit first, input bit last);
        if (first)
            u_vrc_host_model.wait_idle();
        u_vrc_host_model.wr_nib(d);
        if (last)
        begin
            busy_len(t);
            chk(t > c - 4 && t < c + 18, "busy time");
        end
        else
        begin
            repeat (c + 8) @(negedge sys_clk);
            u_vrc_host_model.rd_status(st);
            chk(st[ST_BUSY_BIT] === 1'b1, "busy between nibbles");
        end
    endtask : send
    task automatic give_verdict();
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // ==========================================================
    // scenarios
    initial
    begin
        reset = 1'b1;
        clear_all_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        u_vrc_host_model.rd_status(st);
        chk(st[ST_BUSY_BIT] === 1'b1, "busy in clear");
        clear_all_n = 1'b1;
        busy_len(t);
        chk(t > RC && t < RC + 18, "init time");
        chk(st === 4'h1, "idle status");
        chk(end_of_sequence === 1'b1, "idle eos");
        chk(host_nibble_oe === 1'b0 && address_counter === ADDR_DATA_BASE, "idle");
        send(OP_NOP, CMD_SHORT_CLKS, 1, 1);
        av = 20'(rnd());
        send(OP_CNT_LOAD, CMD_SHORT_CLKS, 1, 0);
        for (int i = 0; i < 5; i++)
            send(av[i*4 +: 4], CMD_SHORT_CLKS, 0, i == 4);
        chk(address_counter === av && end_of_sequence === 1'b1, "load");
        send(OP_START, CMD_SHORT_CLKS, 1, 1);
        chk(end_of_sequence === 1'b0 && t_eos - t_wr inside {[32:52]}, "start");
        send(OP_STOP, CMD_SHORT_CLKS, 1, 1);
        chk(end_of_sequence === 1'b0, "one stop");
        send(OP_STOP, CMD_SHORT_CLKS, 1, 1);
        chk(end_of_sequence === 1'b1, "two stops");
        // start the phrase recordings 400 words below the max address
        av = MAX_A - 20'h0_0190;
        send(OP_CNT_LOAD, CMD_SHORT_CLKS, 1, 0);
        for (int i = 0; i < 5; i++)
            send(av[i*4 +: 4], CMD_SHORT_CLKS, 0, i == 4);
        ph = 6'(rnd());
        send(OP_COND, CMD_SHORT_CLKS, 1, 0);
        send({2'b01, ph[1:0]}, CMD_SHORT_CLKS, 0, 1);
        chk(bit_rate === ph[1:0], "rate");
        send(OP_REC_ARM, CMD_SHORT_CLKS, 1, 1);
        ph = 6'(rnd());
        send(OP_PHRASE, CMD_LONG_CLKS, 1, 0);
        send(ph[3:0], CMD_LONG_CLKS, 0, 0);
        send({2'b00, ph[5:4]}, CMD_LONG_CLKS, 0, 1);
        chk(phrase_number === ph && phrase_mode === 1'b1, "phrase");
        chk(end_of_sequence === 1'b0 && t_eos - t_wr inside {[32:52]}, "rec");
        send(OP_STOP, CMD_SHORT_CLKS, 1, 1);
        chk(end_of_sequence === 1'b1, "rec stop");
        send(OP_PHRASE, CMD_LONG_CLKS, 1, 0);
        send(ph[3:0], CMD_LONG_CLKS, 0, 0);
        send({2'b00, ph[5:4]}, CMD_LONG_CLKS, 0, 1);
        repeat (400) @(negedge sys_clk); // recording runs into the max address
        u_vrc_host_model.rd_status(st);
        chk(st === 4'h5 && address_counter === ADDR_DATA_BASE, "overflow");
        send(OP_NOP, CMD_SHORT_CLKS, 1, 1);
        chk(st === 4'h1, "overflow cleared");
        give_verdict();
    end
endmodule : vrc_cmd_status_tb
`default_nettype wire
